//--- src/clse_core.sv
// Execution core for branches on T/V/I, loads, stores, program memory
// reads, stack, I/O bit and shift/rotate instructions.
// Assumes program, data and I/O memory answer combinationally in the
// cycle after their registered address/strobe.
// Function
// - Branch when copy flag clear, 1/2 cycles
// - Branch on overflow set or clear
// - Branch on interrupt enable set or clear
// - Indirect load then pointer plus one
// - Pointer minus one then indirect load
// - Load at Y/Z plus displacement
// - Load from address in the second instruction word
// - Indirect store then pointer plus one
// - Pointer minus one then indirect store
// - Store at Y/Z plus displacement
// - Store to address in the second instruction word
// - Program memory byte via Z, 3 cycles
// - Push register onto stack, 2 cycles
// - Pop stack byte into register, 2 cycles
// - Set one I/O register bit
// - Clear one I/O register bit
// - Rotate left through carry, flags updated
// - Rotate right through carry, flags updated
// - Logical shifts insert zero, flags updated
`timescale 1ns/1ps
`include "clse_defs.svh"
module clse_core
  import clse_pkg::*;
#(
  parameter logic [15:0] SP_INIT = `CLSE_SP_RST
)(
  input  wire logic         MCLK,
  input  wire logic         RST,
  output clse_dm_req_t      DM_REQ,
  input  wire logic [7:0]   DM_RDATA,
  output clse_io_req_t      IO_REQ,
  input  wire logic [7:0]   IO_RDATA,
  output logic      [15:0]  PM_ADDR,
  input  wire logic [15:0]  PM_DATA,
  input  wire logic         FLAG_LOAD,
  input  wire logic [7:0]   FLAG_IN,
  output logic      [7:0]   STATUS
);

  clse_core_t       q;
  clse_core_t       n;
  logic [31:0][7:0] rf_f;
  logic [3:0]       maj;
  logic [5:0]       op;
  logic [4:0]       fd;
  logic [4:0]       fr;
  logic             is_br;
  logic             br_take;
  logic [15:0]      br_tgt;
  logic             is_disp;
  logic             is_ldst;
  logic             ldst_rd;
  logic [1:0]       psel;
  logic [1:0]       pmode;
  logic [4:0]       pbase;
  logic [4:0]       preg;
  logic [15:0]      pval;
  logic [15:0]      pacc;
  logic [15:0]      pnew;
  logic [15:0]      zval;
  logic [7:0]       rd_v;
  logic             rd_msb;
  logic             rd_lsb;
  logic             is_shift;
  logic             sh_left;
  logic [7:0]       sh_res;
  logic             sh_c;

  function automatic logic [4:0] ptr_base(input logic [1:0] s);
    case (s)
      `CLSE_PTR_X: return `CLSE_X_BASE;
      `CLSE_PTR_Y: return `CLSE_Y_BASE;
      default:     return `CLSE_Z_BASE;
    endcase
  endfunction : ptr_base

  assign maj = PM_DATA[15:12];
  assign op  = PM_DATA[15:10];
  assign fd  = PM_DATA[9:5];
  assign fr  = PM_DATA[4:0];

  // Late load data is folded in first, so a dependent instruction
  // right behind a load sees the new value without a stall.
  always_comb
  begin
    rf_f = q.rf;
    if (q.pend)
      rf_f[q.pend_dst] = q.pend_io ? IO_RDATA : DM_RDATA;
  end

  assign is_br  = (maj == `CLSE_MAJ_BR);
  assign br_tgt = q.pc + 16'h0001 + {{9{PM_DATA[6]}}, PM_DATA[6:0]};

  always_comb
  begin
    case (PM_DATA[11:9])
      `CLSE_BR_TCLR: br_take = ~q.sreg[`CLSE_SR_T];
      `CLSE_BR_VSET: br_take = q.sreg[`CLSE_SR_V];
      `CLSE_BR_VCLR: br_take = ~q.sreg[`CLSE_SR_V];
      `CLSE_BR_ION:  br_take = q.sreg[`CLSE_SR_I];
      `CLSE_BR_IOFF: br_take = ~q.sreg[`CLSE_SR_I];
      default:       br_take = 1'b0;
    endcase
  end

  assign is_disp = (PM_DATA[15:14] == `CLSE_DISP_CLS);
  assign is_ldst = (op == `CLSE_OP_LD) || (op == `CLSE_OP_ST) || is_disp;
  assign ldst_rd = (op == `CLSE_OP_LD) || (is_disp && !PM_DATA[13]);
  assign psel    = is_disp ? (PM_DATA[12] ? `CLSE_PTR_Z : `CLSE_PTR_Y)
                           : fr[1:0];
  assign pmode   = is_disp ? `CLSE_PM_DISP : fr[3:2];
  assign pbase   = ptr_base(psel);
  assign pval    = {rf_f[pbase + 5'h01], rf_f[pbase]};
  assign preg    = is_disp ? fr : fd;
  assign zval    = {rf_f[`CLSE_Z_BASE + 5'h01], rf_f[`CLSE_Z_BASE]};

  clse_ptr_adj #(
    .W (16)
  ) u_ptr (
    .ptr     (pval),
    .mode    (pmode),
    .disp    (PM_DATA[10:5]),
    .acc     (pacc),
    .ptr_new (pnew)
  );

  assign rd_v     = rf_f[fd];
  assign rd_msb   = rd_v[7];
  assign rd_lsb   = rd_v[0];
  assign is_shift = (op >= `CLSE_OP_LSL) && (op <= `CLSE_OP_ROR);
  assign sh_left  = (op == `CLSE_OP_LSL) || (op == `CLSE_OP_ROL);

  always_comb
  begin
    case (op)
      `CLSE_OP_LSL: sh_res = {rd_v[6:0], 1'b0};
      `CLSE_OP_LSR: sh_res = {1'b0, rd_v[7:1]};
      `CLSE_OP_ROL: sh_res = {rd_v[6:0], q.sreg[`CLSE_SR_C]};
      default:      sh_res = {q.sreg[`CLSE_SR_C], rd_v[7:1]};
    endcase
    sh_c = sh_left ? rd_v[7] : rd_v[0];
  end

  always_comb
  begin
    n         = q;
    n.rf      = rf_f;
    n.pend    = 1'b0;
    n.dm.we   = 1'b0;
    n.dm.re   = 1'b0;
    n.io.we   = 1'b0;
    n.io.re   = 1'b0;
    if (FLAG_LOAD)
      n.sreg = FLAG_IN;
    case (q.st)
      ST_EXEC:
      begin
        n.pc = q.pc + 16'h0001;
        if (is_br)
        begin
          if (br_take)
          begin
            n.pc = br_tgt;
            n.st = ST_WAIT;
          end
        end
        else if (maj == `CLSE_MAJ_LDI)
          n.rf[{1'b1, PM_DATA[11:8]}] = PM_DATA[7:0];
        else if (maj == `CLSE_MAJ_IO)
        begin
          n.io.addr = PM_DATA[10:5];
          if (PM_DATA[11])
          begin
            n.io.we    = 1'b1;
            n.io.wdata = rf_f[fr];
          end
          else
          begin
            n.io.re     = 1'b1;
            n.pend      = 1'b1;
            n.pend_io   = 1'b1;
            n.pend_dst  = fr;
          end
        end
        else if (maj == `CLSE_MAJ_IOB)
        begin
          n.io.addr  = PM_DATA[10:5];
          n.io.re    = 1'b1;
          n.iob_bit  = PM_DATA[2:0];
          n.iob_set  = PM_DATA[11];
          n.st       = ST_IOMOD;
        end
        else if (is_ldst)
        begin
          n.dm.addr         = pacc;
          n.st              = ST_WAIT;
          n.rf[pbase]       = pnew[7:0];
          n.rf[pbase+5'h01] = pnew[15:8];
          if (ldst_rd)
          begin
            n.dm.re    = 1'b1;
            n.pend     = 1'b1;
            n.pend_io  = 1'b0;
            n.pend_dst = preg;
          end
          else
          begin
            n.dm.we    = 1'b1;
            n.dm.wdata = rf_f[preg];
          end
        end
        else
        begin
          case (op)
            `CLSE_OP_MOV:  n.rf[fd] = rf_f[fr];
            `CLSE_OP_REGISTER_PAIR_COPY:
            begin
              n.rf[{fd[4:1], 1'b0}] = rf_f[{fr[4:1], 1'b0}];
              n.rf[{fd[4:1], 1'b1}] = rf_f[{fr[4:1], 1'b1}];
            end
            `CLSE_OP_LDS, `CLSE_OP_STS:
            begin
              n.st      = ST_DIR;
              n.dir_st  = (op == `CLSE_OP_STS);
              n.dir_reg = fd;
            end
            `CLSE_OP_LPM:
            begin
              n.st       = ST_LPMR;
              n.pm_addr  = {1'b0, zval[15:1]};
              n.lpm_byte = zval[0];
              n.lpm_dst  = (fr[1:0] == `CLSE_LPM_R0) ? `CLSE_PROD_LOW : fd;
              if (fr[1:0] == `CLSE_LPM_INC)
                {n.rf[`CLSE_Z_BASE + 5'h01], n.rf[`CLSE_Z_BASE]}
                  = zval + 16'h0001;
            end
            `CLSE_OP_PUSH:
            begin
              n.dm.we    = 1'b1;
              n.dm.addr  = q.sp;
              n.dm.wdata = rf_f[fd];
              n.sp       = q.sp - 16'h0001;
              n.st       = ST_WAIT;
            end
            `CLSE_OP_POP:
            begin
              n.sp       = q.sp + 16'h0001;
              n.dm.re    = 1'b1;
              n.dm.addr  = q.sp + 16'h0001;
              n.pend     = 1'b1;
              n.pend_io  = 1'b0;
              n.pend_dst = fd;
              n.st       = ST_WAIT;
            end
            `CLSE_OP_LSL, `CLSE_OP_LSR, `CLSE_OP_ROL, `CLSE_OP_ROR:
            begin
              n.rf[fd]            = sh_res;
              n.sreg[`CLSE_SR_C]  = sh_c;
              n.sreg[`CLSE_SR_Z]  = (sh_res == 8'h00);
              n.sreg[`CLSE_SR_N]  = sh_res[7];
              n.sreg[`CLSE_SR_V]  = sh_res[7] ^ sh_c;
            end
            default: ;
          endcase
        end
        if (n.st != ST_LPMR)
          n.pm_addr = n.pc;
      end
      ST_DIR:
      begin
        n.pc      = q.pc + 16'h0001;
        n.pm_addr = q.pc + 16'h0001;
        n.dm.addr = PM_DATA;
        n.st      = ST_EXEC;
        if (q.dir_st)
        begin
          n.dm.we    = 1'b1;
          n.dm.wdata = rf_f[q.dir_reg];
        end
        else
        begin
          n.dm.re    = 1'b1;
          n.pend     = 1'b1;
          n.pend_io  = 1'b0;
          n.pend_dst = q.dir_reg;
        end
      end
      ST_LPMR:
      begin
        // pick byte, then one refetch cycle
        n.rf[q.lpm_dst] = q.lpm_byte ? PM_DATA[15:8] : PM_DATA[7:0];
        n.pm_addr       = q.pc;
        n.st            = ST_WAIT;
      end
      ST_IOMOD:
      begin
        // write back with one bit forced
        n.io.we    = 1'b1;
        n.io.wdata = IO_RDATA;
        n.io.wdata[q.iob_bit] = q.iob_set;
        n.st       = ST_EXEC;
      end
      ST_WAIT:  n.st = ST_EXEC;
      default:  n.st = ST_EXEC;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      q         <= '0;
      q.st      <= ST_EXEC;
      q.pc      <= `CLSE_PC_RST;
      q.pm_addr <= `CLSE_PC_RST;
      q.sp      <= SP_INIT;
    end
    else
      q <= n;
  end

  assign PM_ADDR = q.pm_addr;
  assign DM_REQ  = q.dm;
  assign IO_REQ  = q.io;
  assign STATUS  = q.sreg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_bubble;
    q.st == ST_WAIT ##1 q.st == ST_EXEC;
  endsequence

  sequence s_lpm;
    q.st == ST_LPMR ##1 s_bubble;
  endsequence

  chk_branch_taken: assert property (
    q.st == ST_EXEC && is_br && br_take
    |=> q.pc == $past(br_tgt) ##0 s_bubble)
    else $error("taken branch target or timing wrong");

  chk_branch_skip: assert property (
    q.st == ST_EXEC && is_br && !br_take && !FLAG_LOAD
    |=> q.st == ST_EXEC && q.pc == $past(q.pc) + 16'h0001
        && q.sreg == $past(q.sreg))
    else $error("untaken branch not single cycle");

  chk_ptr_mem_addr: assert property (
    q.st == ST_EXEC && is_ldst
    |=> (q.dm.re || q.dm.we) && q.dm.addr == $past(pacc)
        && {q.rf[$past(pbase) + 5'h01], q.rf[$past(pbase)]}
           == $past(pnew) ##0 s_bubble)
    else $error("indirect access address or pointer wrong");

  chk_direct_two: assert property (
    q.st == ST_EXEC && !is_br && !is_ldst && maj < `CLSE_MAJ_IOB
    && (op == `CLSE_OP_LDS || op == `CLSE_OP_STS)
    |=> q.st == ST_DIR ##1 q.st == ST_EXEC && (q.dm.re || q.dm.we)
        && q.dm.addr == $past(PM_DATA))
    else $error("direct access not two cycles");

  chk_lpm_three: assert property (
    q.st == ST_EXEC && op == `CLSE_OP_LPM
    |=> PM_ADDR == {1'b0, $past(zval[15:1])} ##0 s_lpm)
    else $error("program memory read not three cycles");

  chk_push_stack: assert property (
    q.st == ST_EXEC && op == `CLSE_OP_PUSH
    |=> q.dm.we && q.dm.addr == $past(q.sp)
        && q.sp == $past(q.sp) - 16'h0001 ##1 q.st == ST_EXEC)
    else $error("push address or stack pointer wrong");

  chk_iobit_force: assert property (
    q.st == ST_EXEC && maj == `CLSE_MAJ_IOB
    |=> q.st == ST_IOMOD ##1 q.io.we
        && q.io.wdata[$past(q.iob_bit)] == $past(q.iob_set))
    else $error("I/O bit change wrong");

  chk_shift_carry: assert property (
    q.st == ST_EXEC && !is_br && maj < `CLSE_MAJ_IOB && is_shift
    && !FLAG_LOAD
    |=> q.sreg[`CLSE_SR_C] == ($past(sh_left) ? $past(rd_msb)
                                              : $past(rd_lsb))
        && q.sreg[`CLSE_SR_V]
           == (q.sreg[`CLSE_SR_N] ^ q.sreg[`CLSE_SR_C]))
    else $error("shift carry or overflow flag wrong");

  chk_copy_single: assert property (
    q.st == ST_EXEC && !FLAG_LOAD && (maj == `CLSE_MAJ_LDI
    || op == `CLSE_OP_MOV || op == `CLSE_OP_REGISTER_PAIR_COPY)
    |=> q.st == ST_EXEC && q.sreg == $past(q.sreg))
    else $error("copy not single cycle or flags changed");

endmodule : clse_core

//--- src/clse_defs.svh
// Constants of the load/store/branch execution core: encodings,
// field values, register indices and reset values.
// Assumes a 16-bit instruction word and a 32 x 8 register file.
`ifndef CLSE_DEFS_SVH
`define CLSE_DEFS_SVH

// Major classes in instruction bits 15:12
`define CLSE_MAJ_BR    4'hF
`define CLSE_MAJ_LDI   4'hE
`define CLSE_MAJ_IO    4'hD
`define CLSE_MAJ_IOB   4'hC
// Displaced access: bits 15:14 equal to this
`define CLSE_DISP_CLS  2'h2
// Register class operations in bits 15:10
`define CLSE_OP_MOV    6'h01
`define CLSE_OP_REGISTER_PAIR_COPY   6'h02
`define CLSE_OP_LD     6'h03
`define CLSE_OP_ST     6'h04
`define CLSE_OP_LDS    6'h05
`define CLSE_OP_STS    6'h06
`define CLSE_OP_LPM    6'h07
`define CLSE_OP_PUSH   6'h08
`define CLSE_OP_POP    6'h09
`define CLSE_OP_LSL    6'h0A
`define CLSE_OP_LSR    6'h0B
`define CLSE_OP_ROL    6'h0C
`define CLSE_OP_ROR    6'h0D
// Branch conditions in bits 11:9
`define CLSE_BR_TCLR   3'h0
`define CLSE_BR_VSET   3'h1
`define CLSE_BR_VCLR   3'h2
`define CLSE_BR_ION    3'h3
`define CLSE_BR_IOFF   3'h4
// Pointer select and pointer modes
`define CLSE_PTR_X     2'h1
`define CLSE_PTR_Y     2'h2
`define CLSE_PTR_Z     2'h3
`define CLSE_PM_PLAIN  2'h0
`define CLSE_PM_INC    2'h1
`define CLSE_PM_DEC    2'h2
`define CLSE_PM_DISP   2'h3
// Program memory read forms
`define CLSE_LPM_R0    2'h0
`define CLSE_LPM_INC   2'h2
// Low byte register of each pointer pair, then the product low byte
`define CLSE_X_BASE    5'h1A
`define CLSE_Y_BASE    5'h1C
`define CLSE_Z_BASE    5'h1E
`define CLSE_PROD_LOW  5'h00
// Status bit positions
`define CLSE_SR_C      0
`define CLSE_SR_Z      1
`define CLSE_SR_N      2
`define CLSE_SR_V      3
`define CLSE_SR_T      6
`define CLSE_SR_I      7
// Reset values
`define CLSE_PC_RST    16'h0000
`define CLSE_SP_RST    16'h03FF

`endif

//--- src/clse_pkg.sv
// Types of the load/store/branch execution core.
// Assumes clse_defs.svh supplies the encodings.
package clse_pkg;

  typedef enum logic [4:0] {
    ST_EXEC  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_DIR   = 5'b00100,
    ST_LPMR  = 5'b01000,
    ST_IOMOD = 5'b10000
  } clse_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } clse_dm_req_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } clse_io_req_t;

  typedef struct packed {
    clse_state_t      st;
    logic [15:0]      pc;
    logic [15:0]      pm_addr;
    logic [15:0]      sp;
    logic [7:0]       sreg;
    logic [31:0][7:0] rf;
    clse_dm_req_t     dm;
    clse_io_req_t     io;
    logic             pend;
    logic             pend_io;
    logic [4:0]       pend_dst;
    logic             dir_st;
    logic [4:0]       dir_reg;
    logic [4:0]       lpm_dst;
    logic             lpm_byte;
    logic [2:0]       iob_bit;
    logic             iob_set;
  } clse_core_t;

endpackage : clse_pkg

//--- src/clse_ptr_adj.sv
// Pointer adjust: access address and written-back pointer value.
// Pure combinational; the caller holds the pointer registers.
`timescale 1ns/1ps
`include "clse_defs.svh"
module clse_ptr_adj
  import clse_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic [W-1:0] ptr,
  input  wire logic [1:0]   mode,
  input  wire logic [5:0]   disp,
  output logic      [W-1:0] acc,
  output logic      [W-1:0] ptr_new
);

  always_comb
  begin
    acc     = ptr;
    ptr_new = ptr;
    case (mode)
      `CLSE_PM_INC:  ptr_new = ptr + W'(1);
      `CLSE_PM_DEC:
      begin
        // Decrement lands before the access
        ptr_new = ptr - W'(1);
        acc     = ptr - W'(1);
      end
      `CLSE_PM_DISP: acc = ptr + W'(disp);
      default: ;
    endcase
  end

endmodule : clse_ptr_adj

//--- test/clse_mem_model.sv
// Program, data and I/O memory on the far side of the execution core.
// Assumes the bench fills pm before reset is released.
`timescale 1ns/1ps
module clse_mem_model
  import clse_pkg::*;
(
  input  wire logic         mclk,
  input  clse_dm_req_t      dm_req,
  output logic      [7:0]   dm_rdata,
  input  clse_io_req_t      io_req,
  output logic      [7:0]   io_rdata,
  input  wire logic [15:0]  pm_addr,
  output logic      [15:0]  pm_data
);
  logic [15:0] pm [0:255];
  logic [7:0]  dm [0:1023];
  logic [7:0]  io [0:63];
  logic [7:0]  dm_last_r;
  logic [7:0]  io_last_r;

  initial
  begin
    for (int i = 0; i < 1024; i++)
      dm[i] = 8'h00;
    for (int i = 0; i < 64; i++)
      io[i] = 8'h00;
    dm_last_r = 8'h00;
    io_last_r = 8'h00;
  end

  // Words beyond the program follow the address, so a stray fetch shows
  assign pm_data  = (pm_addr < 16'h0100) ? pm[pm_addr[7:0]] : ~pm_addr;
  // Outside a read strobe the bus carries the inverse of the last byte
  assign dm_rdata = dm_req.re ? dm[dm_req.addr[9:0]] : ~dm_last_r;
  assign io_rdata = io_req.re ? io[io_req.addr] : ~io_last_r;

  always @(posedge mclk)
  begin
    if (dm_req.we)
      dm[dm_req.addr[9:0]] <= dm_req.wdata;
    if (dm_req.re)
      dm_last_r <= dm_rdata;
    if (io_req.we)
      io[io_req.addr] <= io_req.wdata;
    if (io_req.re)
      io_last_r <= io_rdata;
  end
endmodule : clse_mem_model

//--- test/test_core_load_store_branch_exec.sv
// Self-checking bench: builds a program, keeps a reference model of it
// and compares every data memory write against the noted result.
// Assumes clse_mem_model answers program, data and I/O requests.
`timescale 1ns/1ps
module test_core_load_store_branch_exec
  import clse_pkg::*;
;
  logic         MCLK = 1'b0;
  logic         RST = 1'b1;
  logic         FLAG_LOAD = 1'b0;
  logic [7:0]   FLAG_IN = 8'h00;
  logic [7:0]   DM_RDATA;
  logic [7:0]   IO_RDATA;
  logic [7:0]   STATUS;
  logic [15:0]  PM_ADDR;
  logic [15:0]  PM_DATA;
  clse_dm_req_t DM_REQ;
  clse_io_req_t IO_REQ;
  logic [15:0]  prog [0:255];
  logic [7:0]   rf [0:31];
  logic [7:0]   ioref [0:63];
  logic [7:0]   dref [logic [15:0]];
  logic [23:0]  exp_q [$];
  logic [7:0]   sr;
  logic [15:0]  sp;
  logic [7:0]   pc;
  logic [7:0]   loop_a;
  logic [7:0]   end_a;
  integer       seed = 32'h2A37;
  int           error_cnt = 0;
  int           n_tests = 0;
  int           cyc = 0;

  always #4 MCLK = ~MCLK;

  clse_core DUT (.MCLK(MCLK), .RST(RST), .DM_REQ(DM_REQ),
    .DM_RDATA(DM_RDATA), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA),
    .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .FLAG_LOAD(FLAG_LOAD),
    .FLAG_IN(FLAG_IN), .STATUS(STATUS));

  clse_mem_model MEM (.mclk(MCLK), .dm_req(DM_REQ), .dm_rdata(DM_RDATA),
    .io_req(IO_REQ), .io_rdata(IO_RDATA), .pm_addr(PM_ADDR),
    .pm_data(PM_DATA));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic emit(input logic [15:0] w);
    prog[pc] = w;
    pc++;
  endtask : emit

  task automatic note(input logic [15:0] a, input logic [7:0] v);
    exp_q.push_back({a, v});
    dref[a] = v;
  endtask : note

  task automatic load_immediate(input logic [4:0] d, input logic [7:0] k);
    emit({4'hE, d[3:0], k});
    rf[d] = k;
  endtask : load_immediate

  task automatic register_copy(input logic pair, input logic [4:0] d,
                     input logic [4:0] r);
    emit({pair ? 6'h02 : 6'h01, d, r});
    rf[d] = rf[r];
    if (pair)
      rf[d + 5'h01] = rf[r + 5'h01];
  endtask : register_copy

  task automatic br1(input logic [2:0] c, input logic [4:0] d,
                     input logic [7:0] k);
    logic tk;
    case (c)
      3'h0: tk = !sr[6];
      3'h1: tk = sr[3];
      3'h2: tk = !sr[3];
      3'h3: tk = sr[7];
      3'h4: tk = !sr[7];
      default: tk = 1'b0;
    endcase
    emit({4'hF, c, 2'b00, 7'h01});
    emit({4'hE, d[3:0], k});
    if (!tk)
      rf[d] = k;
  endtask : br1

  task automatic ind(input logic st, input logic [1:0] md,
                     input logic [1:0] ps, input logic [4:0] r);
    logic [4:0]  b;
    logic [15:0] p;
    b = 5'h18 + {2'b00, ps, 1'b0};
    p = {rf[b + 5'h01], rf[b]};
    if (md == 2'h2)
      p = p - 16'h0001;
    emit({st ? 6'h04 : 6'h03, r, 1'b0, md, ps});
    if (st)
      note(p, rf[r]);
    else
      rf[r] = dref[p];
    if (md == 2'h1)
      p = p + 16'h0001;
    {rf[b + 5'h01], rf[b]} = p;
  endtask : ind

  task automatic disp(input logic st, input logic z, input logic [5:0] q,
                      input logic [4:0] r);
    logic [15:0] p;
    p = z ? {rf[31], rf[30]} : {rf[29], rf[28]};
    p = p + {10'h000, q};
    emit({2'b10, st, z, 1'b0, q, r});
    if (st)
      note(p, rf[r]);
    else
      rf[r] = dref[p];
  endtask : disp

  task automatic dir(input logic st, input logic [15:0] a,
                     input logic [4:0] r);
    emit({st ? 6'h06 : 6'h05, r, r});
    emit(a);
    if (st)
      note(a, rf[r]);
    else
      rf[r] = dref[a];
  endtask : dir

  task automatic program_memory_read(input logic [1:0] f, input logic [4:0] d);
    logic [15:0] z;
    logic [15:0] w;
    z = {rf[31], rf[30]};
    w = prog[z[8:1]];
    emit({6'h07, d, 3'b000, f});
    rf[(f == 2'h0) ? 5'h00 : d] = z[0] ? w[15:8] : w[7:0];
    if (f == 2'h2)
      {rf[31], rf[30]} = z + 16'h0001;
  endtask : program_memory_read

  task automatic stk(input logic pop, input logic [4:0] r);
    emit({pop ? 6'h09 : 6'h08, r, 5'h00});
    if (pop)
    begin
      sp = sp + 16'h0001;
      rf[r] = dref[sp];
    end
    else
    begin
      note(sp, rf[r]);
      sp = sp - 16'h0001;
    end
  endtask : stk

  task automatic iop(input logic [3:0] m, input logic s,
                     input logic [5:0] p, input logic [4:0] r);
    emit({m, s, p, r});
    if (m == 4'hC)
      ioref[p][r[2:0]] = s;
    else if (s)
      ioref[p] = rf[r];
    else
      rf[r] = ioref[p];
  endtask : iop

  task automatic sh(input logic [5:0] op, input logic [4:0] d);
    logic [7:0] v;
    logic       nc;
    v = rf[d];
    nc = (op == 6'h0A || op == 6'h0C) ? v[7] : v[0];
    case (op)
      6'h0A: v = {v[6:0], 1'b0};
      6'h0B: v = {1'b0, v[7:1]};
      6'h0C: v = {v[6:0], sr[0]};
      default: v = {sr[0], v[7:1]};
    endcase
    emit({op, d, 5'h00});
    rf[d] = v;
    sr[3:0] = {v[7] ^ nc, v[7], v == 8'h00, nc};
  endtask : sh

  task automatic build;
    for (int i = 0; i < 256; i++)
      prog[i] = 16'h0000;
    for (int i = 0; i < 32; i++)
      rf[i] = 8'h00;
    for (int i = 0; i < 64; i++)
      ioref[i] = 8'h00;
    pc = 8'h00;
    sr = 8'h00;
    sp = 16'h03FF;
    for (int i = 16; i < 24; i++)
      load_immediate(5'(i), 8'($random(seed)));
    load_immediate(26, 8'h10);
    load_immediate(27, 8'h01);
    load_immediate(28, 8'h20);
    load_immediate(29, 8'h01);
    load_immediate(30, 8'h05);
    load_immediate(31, 8'h00);
    loop_a = pc;
    emit({4'hF, 3'h4, 2'b00, 7'h7F});
    sr = 8'h80;
    br1(3, 16, 8'hEE);
    br1(0, 17, 8'hEE);
    br1(1, 24, 8'h5A);
    br1(2, 18, 8'hEE);
    br1(5, 25, 8'hA5);
    br1(4, 19, 8'h3C);
    ind(1, 1, 1, 16);
    ind(1, 0, 1, 17);
    ind(1, 2, 2, 18);
    disp(1, 0, 6'h05, 19);
    dir(1, 16'h0200, 24);
    dir(1, 16'h0201, 25);
    ind(0, 0, 1, 20);
    ind(0, 2, 1, 21);
    ind(0, 1, 2, 22);
    disp(0, 0, 6'h04, 23);
    dir(0, 16'h0200, 1);
    disp(1, 1, 6'h03, 20);
    disp(0, 1, 6'h03, 2);
    program_memory_read(2, 3);
    program_memory_read(0, 4);
    program_memory_read(1, 5);
    ind(1, 1, 3, 5);
    ind(0, 2, 3, 9);
    stk(0, 16);
    stk(0, 17);
    stk(1, 6);
    stk(1, 7);
    iop(4'hD, 1, 6'h05, 16);
    iop(4'hC, 1, 6'h05, 3);
    iop(4'hC, 0, 6'h05, 0);
    iop(4'hD, 0, 6'h05, 8);
    load_immediate(20, 8'h81);
    sh(6'h0A, 20);
    sh(6'h0C, 20);
    load_immediate(21, 8'($random(seed)));
    sh(6'h0B, 21);
    sh(6'h0D, 21);
    br1(1, 22, 8'hEE);
    register_copy(1, 10, 20);
    register_copy(0, 12, 16);
    foreach (rf[i])
      dir(1, 16'h0300 + 16'(i), 5'(i));
    end_a = pc;
    emit({4'hF, 3'h3, 2'b00, 7'h7F});
  endtask : build

  // Mid-cycle sampling: the write pulse stands from edge to edge
  always @(negedge MCLK)
  begin
    cyc++;
    if (!RST && DM_REQ.we === 1'b1)
    begin
      if (exp_q.size() > 0)
        check({DM_REQ.addr, DM_REQ.wdata}, exp_q.pop_front());
      else
        check({DM_REQ.addr, DM_REQ.wdata}, 24'hFFFFFF);
    end
    if (cyc == 3000)
    begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end
  end

  initial
  begin
    build();
    for (int i = 0; i < 256; i++)
      MEM.pm[i] = prog[i];
    repeat (6) @(negedge MCLK);
    RST = 1'b0;
    for (int i = 0; i < 100 && PM_ADDR !== {8'h00, loop_a}; i++)
      @(negedge MCLK);
    repeat (6)
    begin
      @(negedge MCLK);
      check({8'h00, PM_ADDR}, {16'h0000, loop_a});
    end
    FLAG_IN = 8'h80;
    FLAG_LOAD = 1'b1;
    @(negedge MCLK);
    FLAG_LOAD = 1'b0;
    for (int i = 0; i < 2000; i++)
    begin
      if (PM_ADDR === {8'h00, end_a} && exp_q.size() == 0)
        break;
      @(negedge MCLK);
    end
    repeat (4) @(negedge MCLK);
    check({16'h0000, STATUS}, {16'h0000, sr});
    check(24'(exp_q.size()), 24'h000000);
    // A hang before the closing loop must not pass
    check({8'h00, PM_ADDR}, {16'h0000, end_a});
    conclude();
  end
endmodule : test_core_load_store_branch_exec
